// File: rtl/mpps_pkg.sv
// Constants for the request interpreter of the drive parameter server.
// Assumes one core clock; every value here is shared by design and bench.
package mpps_pkg;
  localparam logic [7:0]  FC_RD        = 8'h03;
  localparam logic [7:0]  FC_WR        = 8'h10;
  localparam logic [7:0]  FC_RW        = 8'h17;
  localparam logic [7:0]  FC_EIT       = 8'h2B;
  localparam logic [7:0]  FC_EXC_FLAG  = 8'h80;
  localparam logic [7:0]  FC_RW_EXC    = 8'h97;
  localparam logic [7:0]  FC_EIT_EXC   = 8'hAB;
  localparam logic [7:0]  MEI_DEV_ID   = 8'h0E;
  localparam logic [7:0]  DEV_ID_READ  = 8'h01;
  localparam logic [7:0]  OBJ_START    = 8'h00;
  localparam logic [7:0]  CONFORMITY   = 8'h02;
  localparam logic [7:0]  MORE_FOLLOWS = 8'h00;
  localparam logic [7:0]  NEXT_OBJ     = 8'h00;
  localparam logic [7:0]  OBJ_COUNT    = 8'h03;
  localparam logic [7:0]  OBJ_VENDOR   = 8'h00;
  localparam logic [7:0]  OBJ_PRODUCT  = 8'h01;
  localparam logic [7:0]  OBJ_REVISION = 8'h03;
  localparam logic [7:0]  EXC_NONE     = 8'h00;
  localparam logic [7:0]  EXC_FUNC     = 8'h01;
  localparam logic [7:0]  EXC_ADDR     = 8'h02;
  localparam logic [7:0]  EXC_VALUE    = 8'h03;
  localparam logic [7:0]  EXC_MAX      = 8'h04;
  // Parameter addresses, two register slots per 32-bit parameter.
  localparam logic [15:0] ADDR_SOFT_LIMIT_POSITIVE   = 16'h0608;
  localparam logic [15:0] ADDR_SOFT_LIMIT_NEGATIVE   = 16'h060A;
  localparam logic [15:0] ADDR_FAULT_ENTRY_NUMBER    = 16'h3C02;
  localparam logic [15:0] ADDR_FAULT_ENTRY_CLASS     = 16'h3C04;
  localparam logic [15:0] ADDR_FAULT_ENTRY_TIME      = 16'h3C06;
  localparam logic [15:0] ADDR_FAULT_ENTRY_QUALIFIER = 16'h3C08;
  localparam logic [31:0] SOFT_LIMIT_RESET           = 32'h0000_0000;
  localparam logic [15:0] REGS_PER_PARAM             = 16'h0002;
  // Identification strings; the values are arbitrary.
  localparam int          VEN_LEN = 4;
  localparam int          PRD_LEN = 4;
  localparam int          REV_LEN = 7;
  localparam logic [8*VEN_LEN-1:0] VENDOR_STR   = "ACME";
  localparam logic [8*PRD_LEN-1:0] PRODUCT_STR  = "DRV1";
  localparam logic [8*REV_LEN-1:0] REVISION_STR = "V01.000";
  // Byte positions and lengths inside a request and a response.
  localparam int RX_RD_HDR = 5;
  localparam int RX_WR_HDR = 6;
  localparam int RX_RW_HDR = 10;
  localparam int RX_ID_LEN = 4;
  localparam int TX_WR_LEN = 5;
  localparam int TX_ID_HDR = 7;
  localparam int TX_ID_LEN = TX_ID_HDR + 6 + VEN_LEN + PRD_LEN + REV_LEN;
  typedef enum logic [1:0] {
    S_RX   = 2'b00,
    S_EXEC = 2'b01,
    S_TX   = 2'b10
  } mpps_state_t;
endpackage

// File: rtl/mpps_server.sv
// Request interpreter: takes one request PDU as a byte stream, executes it against
// the parameter store and streams back a positive or exception response PDU.
// Assumes the transport below delivers whole PDUs on the core clock domain.
// What this block does
// (R1) Function 0x17 reads and writes consecutive parameters in one transaction.
// (R2) Combined request: read addr, read qty, write addr, write qty, byte count, data.
// (R3) Each 32-bit parameter counts as two 16-bit register slots.
// (R4) Combined success reply: function code, byte count, read values.
// (R5) Combined failure reply: 0x97 then exception code 0x01 to 0x04.
// (R6) Identification request carries 0x2B, 0x0E, 0x01, object 0x00.
// (R7) Identification reply echoes header, then 0x02, 0x00, 0x00, 0x03.
// (R8) Each identification object is id byte, length byte, value bytes.
// (R9) Failed identification request is answered with 0xAB and exception code.
// (R10) Objects 0x00 vendor, 0x01 product code, 0x03 revision string.
// (R11) Parameter addresses ascend by two; one request covers adjacent parameters.
// (R12) Write-multiple success echoes start address and quantity, not the data.
// (R13) Any unservable request gets function code plus 0x80 and exception code.
`timescale 1ns/1ps
module mpps_server #(
  parameter int RXN         = 20,   // Request buffer bytes.
  parameter int TXN         = 32,   // Response buffer bytes.
  parameter int MAX_RD_REGS = 8,    // Largest read quantity in registers.
  parameter int MAX_WR_REGS = 4     // Largest write quantity in registers.
) (
  input  wire logic        core_clk,         // Core clock, 40 MHz.
  input  wire logic        rst,              // Synchronous reset, active high.
  input  wire logic        req_valid,        // Request byte present.
  input  wire logic [7:0]  req_data,         // Request byte.
  input  wire logic        req_last,         // Last byte of the request PDU.
  output logic             req_ready,        // Request byte accepted when high.
  output logic             rsp_valid,        // Response byte present.
  output logic [7:0]       rsp_data,         // Response byte.
  output logic             rsp_last,         // Last byte of the response PDU.
  input  wire logic        rsp_ready,        // Transport takes the response byte.
  input  wire logic [31:0] fault_number,     // Fault memory entry number.
  input  wire logic [31:0] fault_class,      // Fault memory entry class.
  input  wire logic [31:0] fault_time,       // Fault memory entry time.
  input  wire logic [31:0] fault_qualifier,  // Fault memory entry qualifier.
  output logic [31:0]      soft_limit_pos,   // Positive software limit.
  output logic [31:0]      soft_limit_neg    // Negative software limit.
);
  import mpps_pkg::*;

  typedef struct packed {
    mpps_state_t          st;
    logic [RXN-1:0][7:0]  rx;
    logic [5:0]           rx_cnt;
    logic                 ovf;
    logic [TXN-1:0][7:0]  tx;
    logic [5:0]           tx_len;
    logic [5:0]           tx_idx;
    logic [7:0]           exc;
    logic [31:0]          lim_pos;
    logic [31:0]          lim_neg;
    logic                 req_ready;
    logic                 rsp_valid;
    logic [7:0]           rsp_data;
    logic                 rsp_last;
  } mpps_regs_t;

  mpps_regs_t r_reg;
  mpps_regs_t r_next;

  // Read lookup; bit 32 says whether the address names a parameter.
  function automatic logic [32:0] rd_param(input logic [15:0] a, input logic [31:0] lp,
                                           input logic [31:0] ln);
    case (a)
      ADDR_SOFT_LIMIT_POSITIVE:   rd_param = {1'b1, lp};
      ADDR_SOFT_LIMIT_NEGATIVE:   rd_param = {1'b1, ln};
      ADDR_FAULT_ENTRY_NUMBER:    rd_param = {1'b1, fault_number};
      ADDR_FAULT_ENTRY_CLASS:     rd_param = {1'b1, fault_class};
      ADDR_FAULT_ENTRY_TIME:      rd_param = {1'b1, fault_time};
      ADDR_FAULT_ENTRY_QUALIFIER: rd_param = {1'b1, fault_qualifier};
      default:                    rd_param = '0;
    endcase
  endfunction

  always_comb begin
    logic        do_rd;
    logic        do_wr;
    logic [15:0] rs;
    logic [15:0] rq;
    logic [15:0] ws;
    logic [15:0] wq;
    logic [7:0]  wbc;
    int          wd;
    int          exp_len;
    int          pos;
    logic [7:0]  exc;
    logic [7:0]  fc;
    logic [15:0] a;
    logic [31:0] v;
    logic [32:0] look;
    do_rd   = 1'b0;
    do_wr   = 1'b0;
    rs      = '0;
    rq      = '0;
    ws      = '0;
    wq      = '0;
    wbc     = '0;
    wd      = 0;
    exp_len = 0;
    pos     = 0;
    exc     = EXC_NONE;
    fc      = r_reg.rx[0];
    a       = '0;
    v       = '0;
    look    = '0;
    r_next  = r_reg;
    case (r_reg.st)
      S_RX: begin
        if (req_valid && r_reg.req_ready) begin
          if (int'(r_reg.rx_cnt) < RXN) begin
            r_next.rx[r_reg.rx_cnt] = req_data;
            r_next.rx_cnt = r_reg.rx_cnt + 6'h01;
          end else begin
            r_next.ovf = 1'b1;
          end
          if (req_last) begin
            r_next.req_ready = 1'b0;
            r_next.st = S_EXEC;
          end
        end
      end
      S_EXEC: begin
        case (fc)
          FC_RD: begin
            do_rd = 1'b1;
            rs = {r_reg.rx[1], r_reg.rx[2]};
            rq = {r_reg.rx[3], r_reg.rx[4]};
            exp_len = RX_RD_HDR;
          end
          FC_WR: begin
            do_wr = 1'b1;
            ws = {r_reg.rx[1], r_reg.rx[2]};
            wq = {r_reg.rx[3], r_reg.rx[4]};
            wbc = r_reg.rx[5];
            wd = RX_WR_HDR;
            exp_len = RX_WR_HDR + int'(wbc);
          end
          FC_RW: begin                                     // see (R1)
            do_rd = 1'b1;
            do_wr = 1'b1;
            rs = {r_reg.rx[1], r_reg.rx[2]};               // see (R2)
            rq = {r_reg.rx[3], r_reg.rx[4]};
            ws = {r_reg.rx[5], r_reg.rx[6]};
            wq = {r_reg.rx[7], r_reg.rx[8]};
            wbc = r_reg.rx[9];
            wd = RX_RW_HDR;
            exp_len = RX_RW_HDR + int'(wbc);
          end
          FC_EIT: begin
            exp_len = RX_ID_LEN;
            if (r_reg.rx[1] != MEI_DEV_ID) begin
              exc = EXC_FUNC;
            end else if (r_reg.rx[2] != DEV_ID_READ || r_reg.rx[3] != OBJ_START) begin
              exc = EXC_VALUE;                             // see (R6)
            end
          end
          default: exc = EXC_FUNC;                         // see (R13)
        endcase
        if (exc == EXC_NONE && (r_reg.ovf || int'(r_reg.rx_cnt) != exp_len)) begin
          exc = EXC_VALUE;
        end
        // Quantities must cover whole parameters, two slots each.
        if (exc == EXC_NONE && do_rd && (rq == '0 || rq[0] || int'(rq) > MAX_RD_REGS)) begin
          exc = EXC_VALUE;                                 // see (R3)
        end
        if (exc == EXC_NONE && do_wr && (wq == '0 || wq[0] || int'(wq) > MAX_WR_REGS
            || {8'h00, wbc} != (wq << 1))) begin
          exc = EXC_VALUE;                                 // see (R2)
        end
        // All addresses are checked before anything is written, so a refused
        // request never leaves the store half updated.
        for (int p = 0; p < MAX_WR_REGS / 2; p++) begin
          a = ws + 16'(2 * p);                             // see (R11)
          if (exc == EXC_NONE && do_wr && p < int'(wq) / 2 &&
              a != ADDR_SOFT_LIMIT_POSITIVE && a != ADDR_SOFT_LIMIT_NEGATIVE) begin
            exc = EXC_ADDR;
          end
        end
        for (int p = 0; p < MAX_RD_REGS / 2; p++) begin
          look = rd_param(rs + 16'(2 * p), r_reg.lim_pos, r_reg.lim_neg);
          if (exc == EXC_NONE && do_rd && p < int'(rq) / 2 && !look[32]) begin
            exc = EXC_ADDR;
          end
        end
        // Writes land before reads, so a combined request reads back new values.
        for (int p = 0; p < MAX_WR_REGS / 2; p++) begin
          if (exc == EXC_NONE && do_wr && p < int'(wq) / 2) begin
            a = ws + 16'(2 * p);
            pos = wd + 4 * p;
            v = {r_reg.rx[pos], r_reg.rx[pos+1], r_reg.rx[pos+2], r_reg.rx[pos+3]};
            if (a == ADDR_SOFT_LIMIT_POSITIVE) begin
              r_next.lim_pos = v;                          // see (R11)
            end else begin
              r_next.lim_neg = v;
            end
          end
        end
        r_next.tx = '0;
        r_next.tx[0] = fc;
        if (exc != EXC_NONE) begin
          r_next.tx[0] = fc | FC_EXC_FLAG;                 // see (R5) see (R9) see (R13)
          r_next.tx[1] = exc;
          r_next.tx_len = 6'd2;
        end else if (do_rd) begin
          r_next.tx[1] = 8'(rq << 1);                      // see (R4)
          r_next.tx_len = 6'(2 + 2 * int'(rq));
          for (int p = 0; p < MAX_RD_REGS / 2; p++) begin
            look = rd_param(rs + 16'(2 * p), r_next.lim_pos, r_next.lim_neg);
            if (p < int'(rq) / 2) begin
              for (int b = 0; b < 4; b++) begin
                r_next.tx[2 + 4 * p + b] = look[8 * (3 - b) +: 8];
              end
            end
          end
        end else if (do_wr) begin
          for (int b = 1; b < TX_WR_LEN; b++) begin
            r_next.tx[b] = r_reg.rx[b];                    // see (R12)
          end
          r_next.tx_len = 6'(TX_WR_LEN);
        end else begin
          r_next.tx[1] = MEI_DEV_ID;                       // see (R7)
          r_next.tx[2] = r_reg.rx[2];
          r_next.tx[3] = CONFORMITY;
          r_next.tx[4] = MORE_FOLLOWS;
          r_next.tx[5] = NEXT_OBJ;
          r_next.tx[6] = OBJ_COUNT;
          pos = TX_ID_HDR;
          r_next.tx[pos] = OBJ_VENDOR;                     // see (R8) see (R10)
          r_next.tx[pos+1] = 8'(VEN_LEN);
          for (int i = 0; i < VEN_LEN; i++) begin
            r_next.tx[pos+2+i] = VENDOR_STR[8 * (VEN_LEN - 1 - i) +: 8];
          end
          pos = pos + 2 + VEN_LEN;
          r_next.tx[pos] = OBJ_PRODUCT;
          r_next.tx[pos+1] = 8'(PRD_LEN);
          for (int i = 0; i < PRD_LEN; i++) begin
            r_next.tx[pos+2+i] = PRODUCT_STR[8 * (PRD_LEN - 1 - i) +: 8];
          end
          pos = pos + 2 + PRD_LEN;
          r_next.tx[pos] = OBJ_REVISION;
          r_next.tx[pos+1] = 8'(REV_LEN);
          for (int i = 0; i < REV_LEN; i++) begin
            r_next.tx[pos+2+i] = REVISION_STR[8 * (REV_LEN - 1 - i) +: 8];
          end
          r_next.tx_len = 6'(TX_ID_LEN);
        end
        r_next.exc = exc;
        r_next.st = S_TX;
        r_next.rsp_valid = 1'b1;
        r_next.rsp_data = r_next.tx[0];
        r_next.rsp_last = 1'b0;
        r_next.tx_idx = 6'd1;
      end
      S_TX: begin
        if (r_reg.rsp_valid && rsp_ready) begin
          if (r_reg.rsp_last) begin
            r_next.rsp_valid = 1'b0;
            r_next.rsp_last = 1'b0;
            r_next.rx_cnt = '0;
            r_next.ovf = 1'b0;
            r_next.req_ready = 1'b1;
            r_next.st = S_RX;
          end else begin
            r_next.rsp_data = r_reg.tx[r_reg.tx_idx];
            r_next.rsp_last = (r_reg.tx_idx == r_reg.tx_len - 6'd1);
            r_next.tx_idx = r_reg.tx_idx + 6'd1;
          end
        end
      end
      default: r_next.st = S_RX;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      r_reg           <= '0;
      r_reg.st        <= S_RX;
      r_reg.lim_pos   <= SOFT_LIMIT_RESET;
      r_reg.lim_neg   <= SOFT_LIMIT_RESET;
      r_reg.req_ready <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign req_ready      = r_reg.req_ready;
  assign rsp_valid      = r_reg.rsp_valid;
  assign rsp_data       = r_reg.rsp_data;
  assign rsp_last       = r_reg.rsp_last;
  assign soft_limit_pos = r_reg.lim_pos;
  assign soft_limit_neg = r_reg.lim_neg;

  property p_rw_first_byte;
    @(posedge core_clk) disable iff (rst)
    r_reg.st == S_EXEC && r_reg.rx[0] == FC_RW |=> rsp_valid &&
      (rsp_data == FC_RW || rsp_data == FC_RW_EXC);
  endproperty
  a_rw_first_byte: assert property (p_rw_first_byte) else $error("bad combined reply code"); // see (R1)
  property p_rw_count;
    @(posedge core_clk) disable iff (rst)
    r_reg.st == S_TX && r_reg.exc == EXC_NONE && r_reg.rx[0] == FC_RW |->
      r_reg.rx[9] == 8'({r_reg.rx[7], r_reg.rx[8]} << 1);
  endproperty
  a_rw_count: assert property (p_rw_count) else $error("combined write count accepted wrong"); // see (R2)
  property p_rw_reply;
    @(posedge core_clk) disable iff (rst)
    r_reg.st == S_TX && r_reg.exc == EXC_NONE && r_reg.rx[0] == FC_RW |->
      r_reg.tx[1] == 8'({r_reg.rx[3], r_reg.rx[4]} << 1) && r_reg.tx[1] + 8'h02 == 8'(r_reg.tx_len);
  endproperty
  a_rw_reply: assert property (p_rw_reply) else $error("combined reply byte count wrong"); // see (R4)
  property p_rw_exc;
    @(posedge core_clk) disable iff (rst)
    r_reg.st == S_TX && r_reg.exc != EXC_NONE && r_reg.rx[0] == FC_RW |-> r_reg.tx[0] == FC_RW_EXC;
  endproperty
  a_rw_exc: assert property (p_rw_exc) else $error("combined exception code wrong"); // see (R5)
  property p_id_hdr;
    @(posedge core_clk) disable iff (rst)
    r_reg.st == S_TX && r_reg.exc == EXC_NONE && r_reg.rx[0] == FC_EIT |->
      r_reg.tx[3] == CONFORMITY && r_reg.tx[4] == MORE_FOLLOWS && r_reg.tx[6] == OBJ_COUNT;
  endproperty
  a_id_hdr: assert property (p_id_hdr) else $error("identification header wrong"); // see (R7)
  property p_id_obj;
    @(posedge core_clk) disable iff (rst)
    r_reg.st == S_TX && r_reg.exc == EXC_NONE && r_reg.rx[0] == FC_EIT |->
      r_reg.tx[TX_ID_HDR] == OBJ_VENDOR && r_reg.tx[TX_ID_HDR+1] == 8'(VEN_LEN)
      && r_reg.tx[TX_ID_HDR+2+VEN_LEN] == OBJ_PRODUCT;
  endproperty
  a_id_obj: assert property (p_id_obj) else $error("identification object layout wrong"); // see (R8)
  property p_id_exc;
    @(posedge core_clk) disable iff (rst)
    r_reg.st == S_TX && r_reg.exc != EXC_NONE && r_reg.rx[0] == FC_EIT |-> r_reg.tx[0] == FC_EIT_EXC;
  endproperty
  a_id_exc: assert property (p_id_exc) else $error("identification exception code wrong"); // see (R9)
  property p_exc_form;
    @(posedge core_clk) disable iff (rst)
    $rose(rsp_valid) && r_reg.exc != EXC_NONE |-> r_reg.tx_len == 6'd2 && r_reg.exc <= EXC_MAX
      && rsp_data == (r_reg.rx[0] | FC_EXC_FLAG);
  endproperty
  a_exc_form: assert property (p_exc_form) else $error("exception reply malformed"); // see (R13)
  property p_wr_echo;
    @(posedge core_clk) disable iff (rst)
    r_reg.st == S_TX && r_reg.exc == EXC_NONE && r_reg.rx[0] == FC_WR |->
      r_reg.tx_len == 6'(TX_WR_LEN) && r_reg.tx[3] == r_reg.rx[3] && r_reg.tx[4] == r_reg.rx[4];
  endproperty
  a_wr_echo: assert property (p_wr_echo) else $error("write reply echo wrong"); // see (R12)
  property p_wr_run;
    @(posedge core_clk) disable iff (rst)
    r_reg.st == S_EXEC && r_next.exc == EXC_NONE && r_reg.rx[0] == FC_WR &&
      {r_reg.rx[1], r_reg.rx[2]} == ADDR_SOFT_LIMIT_POSITIVE && r_reg.rx[4] == 8'h04 |=>
      soft_limit_neg == {r_reg.rx[10], r_reg.rx[11], r_reg.rx[12], r_reg.rx[13]};
  endproperty
  a_wr_run: assert property (p_wr_run) else $error("second parameter of run not written"); // see (R11)
endmodule // mpps_server

// File: sim/mpps_client.sv
// Partner model: the transport-side client that streams request PDUs into the
// server and collects the response PDUs, optionally stalling rsp_ready.
// Assumes the server serves one request at a time on core_clk.
`timescale 1ns/1ps
module mpps_client (
  input  wire logic       core_clk,   // Core clock.
  output logic            req_valid,  // Request byte present.
  output logic [7:0]      req_data,   // Request byte.
  output logic            req_last,   // Last request byte.
  input  wire logic       req_ready,  // Server takes the byte.
  input  wire logic       rsp_valid,  // Response byte present.
  input  wire logic [7:0] rsp_data,   // Response byte.
  input  wire logic       rsp_last,   // Last response byte.
  output logic            rsp_ready   // Client takes the byte.
);
  initial begin
    req_valid = 1'b0;
    req_data  = 8'h00;
    req_last  = 1'b0;
    rsp_ready = 1'b0;
  end

  // A byte is held until an edge that samples req_ready high, so none is lost
  // while the server is still busy with the previous answer.
  task automatic xfer(input logic [7:0] rq[$], input int stall,
                      output logic [7:0] rs[$], output int lat);
    int cnt;
    bit done;
    cnt  = 0;
    done = 1'b0;
    lat  = -1;
    rs   = {};
    @(posedge core_clk);
    foreach (rq[i]) begin
      req_valid <= 1'b1;
      req_data  <= rq[i];
      req_last  <= (i == rq.size() - 1);
      do @(negedge core_clk); while (req_ready !== 1'b1);
      @(posedge core_clk);
    end
    req_valid <= 1'b0;
    req_last  <= 1'b0;
    // The released data line shows the inverse, so a stale byte is never reused.
    req_data  <= ~req_data;
    while (!done) begin
      rsp_ready <= (cnt % (stall + 1)) == stall;
      @(negedge core_clk);
      if (rsp_valid === 1'b1 && lat < 0) lat = cnt;
      if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
        rs.push_back(rsp_data);
        done = (rsp_last === 1'b1);
      end
      cnt++;
      @(posedge core_clk);
    end
    rsp_ready <= 1'b0;
  endtask
endmodule // mpps_client

// File: sim/test_modbus_pdu_parameter_server.sv
// Self-checking bench for the parameter server: a table of requests and their
// expected responses, then answer latency, oversize and reset cases.
// Assumes the package and the client model are compiled before this file.
`timescale 1ns/1ps
module test_modbus_pdu_parameter_server;
  import mpps_pkg::*;
  localparam logic [31:0] FN = 32'hA1B2_C3D4;
  localparam logic [31:0] FC = 32'h0000_0007;
  localparam logic [31:0] FT = 32'h1234_5678;
  localparam logic [31:0] FQ = 32'hFEDC_0001;
  localparam logic [31:0] LP = 32'h0001_86A0;
  localparam logic [31:0] LN = 32'hFFFE_7960;
  localparam logic [31:0] LM = 32'h8000_0001;
  typedef struct {
    logic [223:0] rq;
    int           rl;
    logic [223:0] ex;
    int           el;
    int           st;
  } mpps_row_t;

  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        req_valid, req_last, req_ready, rsp_valid, rsp_last, rsp_ready;
  logic [7:0]  req_data, rsp_data;
  logic [31:0] soft_limit_pos, soft_limit_neg;
  int          n_mismatch = 0;
  int          checks = 0;
  int          lat;

  mpps_row_t rows [13] = '{
    '{{FC_RD, 16'h3C02, 16'h0008}, 5,
      {FC_RD, 8'h10, FN, FC, FT, FQ}, 18, 0},
    '{{FC_WR, 16'h0608, 16'h0004, 8'h08, LP, LN}, 14,
      {FC_WR, 16'h0608, 16'h0004}, 5, 1},
    '{{FC_RD, 16'h0608, 16'h0004}, 5, {FC_RD, 8'h08, LP, LN}, 10, 3},
    '{{FC_RW, 16'h0608, 16'h0004, 16'h060A, 16'h0002, 8'h04, LM}, 14,
      {FC_RW, 8'h08, LP, LM}, 10, 0},
    '{{FC_EIT, MEI_DEV_ID, DEV_ID_READ, OBJ_START}, 4,
      {FC_EIT, MEI_DEV_ID, DEV_ID_READ, CONFORMITY, MORE_FOLLOWS, NEXT_OBJ, OBJ_COUNT,
       OBJ_VENDOR, 8'(VEN_LEN), VENDOR_STR, OBJ_PRODUCT, 8'(PRD_LEN), PRODUCT_STR,
       OBJ_REVISION, 8'(REV_LEN), REVISION_STR}, 28, 2},
    '{{8'h05}, 1, {8'h85, EXC_FUNC}, 2, 0},
    '{{FC_RW, 16'h0608, 16'h0002, 16'h3C02, 16'h0002, 8'h04, LP}, 14,
      {FC_RW_EXC, EXC_ADDR}, 2, 1},
    '{{FC_EIT, 8'h0D, DEV_ID_READ, OBJ_START}, 4,
      {FC_EIT_EXC, EXC_FUNC}, 2, 0},
    '{{FC_EIT, MEI_DEV_ID, 8'h02, OBJ_START}, 4,
      {FC_EIT_EXC, EXC_VALUE}, 2, 0},
    '{{FC_RD, 16'h3C02, 16'h0003}, 5, {8'h83, EXC_VALUE}, 2, 0},
    '{{FC_RD, 16'h3C02, 16'h000A}, 5, {8'h83, EXC_VALUE}, 2, 0},
    '{{FC_WR, 16'h060A, 16'h0002, 8'h08, LP}, 10, {8'h90, EXC_VALUE}, 2, 0},
    '{{FC_WR, 16'h3C02, 16'h0002, 8'h04, LP}, 10, {8'h90, EXC_ADDR}, 2, 0}
  };

  always #12.5 core_clk = ~core_clk;

  mpps_server mpps_server_inst (
    .core_clk        (core_clk),
    .rst             (rst),
    .req_valid       (req_valid),
    .req_data        (req_data),
    .req_last        (req_last),
    .req_ready       (req_ready),
    .rsp_valid       (rsp_valid),
    .rsp_data        (rsp_data),
    .rsp_last        (rsp_last),
    .rsp_ready       (rsp_ready),
    .fault_number    (FN),
    .fault_class     (FC),
    .fault_time      (FT),
    .fault_qualifier (FQ),
    .soft_limit_pos  (soft_limit_pos),
    .soft_limit_neg  (soft_limit_neg)
  );

  mpps_client mpps_client_inst (
    .core_clk  (core_clk),
    .req_valid (req_valid),
    .req_data  (req_data),
    .req_last  (req_last),
    .req_ready (req_ready),
    .rsp_valid (rsp_valid),
    .rsp_data  (rsp_data),
    .rsp_last  (rsp_last),
    .rsp_ready (rsp_ready)
  );

  task automatic cmp_v(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_n(input int got, input int exp);
    checks++;
    if (got != exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Rows hold their bytes right-aligned, first byte in the highest lane.
  task automatic run(input mpps_row_t r, output int l);
    logic [7:0] rq[$];
    logic [7:0] rs[$];
    for (int i = r.rl - 1; i >= 0; i--) rq.push_back(r.rq[8*i +: 8]);
    mpps_client_inst.xfer(rq, r.st, rs, l);
    cmp_n(rs.size(), r.el);
    for (int i = 0; i < r.el; i++) cmp_v(32'(rs[i]), 32'(r.ex[8*(r.el-1-i) +: 8]));
  endtask

  task automatic close_out;
    $display("mismatches=%0d checks=%0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    close_out();
  end

  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    foreach (rows[k]) run(rows[k], lat);
    cmp_v(soft_limit_pos, LP);
    cmp_v(soft_limit_neg, LM);
    // One execute cycle passes after the last request byte, so the first answer
    // byte stands in the second cycle that the client counts.
    run('{{FC_RD, 16'h3C02, 16'h0002}, 5, {FC_RD, 8'h04, FN}, 6, 0}, lat);
    cmp_n(lat, 1);
    // A request longer than the buffer is refused as a bad value.
    run('{{FC_RD, 16'h3C02, 16'h0008, 128'h0}, 21, {8'h83, EXC_VALUE}, 2, 0}, lat);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    cmp_v(32'(req_ready), 32'h1);
    cmp_v(32'(rsp_valid), 32'h0);
    cmp_v(32'(rsp_last), 32'h0);
    cmp_v(32'(rsp_data), 32'h0);
    cmp_v(soft_limit_pos, SOFT_LIMIT_RESET);
    cmp_v(soft_limit_neg, SOFT_LIMIT_RESET);
    @(posedge core_clk);
    rst <= 1'b0;
    run('{{FC_RD, 16'h0608, 16'h0004}, 5,
          {FC_RD, 8'h08, SOFT_LIMIT_RESET, SOFT_LIMIT_RESET}, 10, 1}, lat);
    close_out();
  end
endmodule // test_modbus_pdu_parameter_server
